/* File: bench/bclc_host_model.sv */
`timescale 1ns/10ps
`default_nettype none
// Host software side: one write and one read at a time, each wait bounded
module bclc_host_model (
  input wire logic clk, // Clock
  output logic [7:0] awaddr, // Write address
  output logic awvalid, // Address valid
  input wire logic awready, // Address taken
  output logic [31:0] wdata, // Write data
  output logic wvalid, // Data valid
  input wire logic wready, // Data taken
  input wire logic [1:0] bresp, // Write answer
  input wire logic bvalid, // Answer valid
  output logic bready, // Answer ready
  output logic [7:0] araddr, // Read address
  output logic arvalid, // Read valid
  input wire logic arready, // Read taken
  input wire logic [31:0] rdata, // Read data
  input wire logic [1:0] rresp, // Read answer
  input wire logic rvalid, // Answer valid
  output logic rready // Answer ready
);
  initial {awaddr, awvalid, wdata, wvalid, bready, araddr, arvalid, rready} = '0;
  // Payload is inverted once taken so a stale value never looks valid
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r,
                    output bit to);
    int n;
    @(posedge clk);
    {awaddr, wdata, awvalid, wvalid, bready} <= {a, d, 3'b111};
    n = 0;
    do begin
      @(posedge clk);
      n++;
      if (awready && awvalid) begin
        awvalid <= 1'b0;
        awaddr <= ~a;
      end
      if (wready && wvalid) begin
        wvalid <= 1'b0;
        wdata <= ~d;
      end
    end while (!bvalid && n < 200);
    r = bresp;
    to = !bvalid;
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r,
                    output bit to);
    int n;
    @(posedge clk);
    {araddr, arvalid, rready} <= {a, 2'b11};
    n = 0;
    do begin
      @(posedge clk);
      n++;
      if (arready && arvalid) begin
        arvalid <= 1'b0;
        araddr <= ~a;
      end
    end while (!rvalid && n < 200);
    {d, r} = {rdata, rresp};
    to = !rvalid;
    rready <= 1'b0;
  endtask
endmodule
`default_nettype wire

/* File: bench/test_bclc_top.sv */
`timescale 1ns/10ps
`default_nettype none
module test_bclc_top;
  import bclc_pkg::*;
  logic clk = 1'b0; // 250 MHz clock
  logic rst = 1'b1; // Held for 10 cycles
  logic hall_step = 1'b0; // Hall pulse
  logic hall_dir = 1'b1; // Hall direction
  logic home_switch = 1'b0; // Home pin
  logic ref_search_done = 1'b0; // Search end
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, emf, tgt;
  logic [1:0] bresp, rresp, mode;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic hs, ls, inv, sreq;
  logic [3:0] hc, lc;
  logic [2:0] hm, lm, sens;
  int n_errors = 0;
  int checks = 0;
  always #2 clk = ~clk;
  // Clock enable and byte strobes stay on: every access is a whole word
  bclc_top dut_u (.clk(clk), .rst(rst), .ce(1'b1), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .hall_step(hall_step), .hall_dir(hall_dir),
    .home_switch(home_switch), .ref_search_done(ref_search_done), .high_act_stb(hs),
    .high_act_code(hc), .high_act_motors(hm), .low_act_stb(ls), .low_act_code(lc),
    .low_act_motors(lm), .commutation_mode(mode), .rotor_sensor_select(sens),
    .emf_coupling_constant(emf), .speed_invert(inv), .ref_search_req(sreq),
    .position_target(tgt));
  bclc_host_model host_u (.clk(clk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready));
  task automatic print_verdict;
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic cmp(input string what, input logic [31:0] ex, input logic [31:0] got);
    checks++;
    if (got !== ex) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", what, ex, got);
    end
  endtask
  // A lost answer counts as a mismatch and ends the run
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = RESP_OKAY);
    logic [1:0] r;
    bit to;
    host_u.wr(a, d, r, to);
    if (to) begin
      n_errors++;
      print_verdict();
    end
    cmp("bresp", 32'(er), 32'(r));
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] ex,
                       input logic [1:0] er = RESP_OKAY);
    logic [31:0] d;
    logic [1:0] r;
    bit to;
    host_u.rd(a, d, r, to);
    if (to) begin
      n_errors++;
      print_verdict();
    end
    cmp("rresp", 32'(er), 32'(r));
    cmp("rdata", ex, d);
  endtask
  // One hall pulse, then a window that covers the watcher latency
  task automatic step(input logic d, output bit hi, output bit lo);
    hall_dir <= d;
    hall_step <= 1'b1;
    @(posedge clk);
    hall_step <= 1'b0;
    {hi, lo} = 2'b00;
    repeat (4) begin
      @(posedge clk);
      hi |= hs;
      lo |= ls;
    end
  endtask
  task automatic t_reset;
    rdchk(OFS_HIGH_LIMIT, 32'h00004E20);
    rdchk(OFS_LOW_LIMIT, 32'hFFFFB1E0);
    rdchk(OFS_HIGH_ACTION, 32'h0);
    rdchk(OFS_LOW_ACTION, 32'h0);
    rdchk(OFS_HOME_VALUE, 32'h0);
    rdchk(OFS_MODE, 32'h0);
    rdchk(OFS_EMF_COUPLING, 32'h0);
    rdchk(8'h3C, 32'h0, RESP_SLVERR);
    $display("reset test done");
  endtask
  // Every action code, motor nibble cycling through 1, 2 and 3; code 0 stays quiet
  task automatic t_high;
    bit hi, lo;
    wr(OFS_HIGH_LIMIT, 32'h00000003);
    wr(OFS_HOME_VALUE, 32'h00000064);
    for (int c = 0; c <= 8; c++) begin
      wr(OFS_COUNTER, 32'h00000003);
      wr(OFS_HIGH_ACTION, 32'(c + 16 * (c % 3 + 1)));
      step(1'b1, hi, lo);
      cmp("high fired", 32'(c != 0), 32'(hi));
      if (c != 0) begin
        cmp("high code", 32'(c), 32'(hc));
        cmp("high mask", 32'(1 << (c % 3)), 32'(hm));
      end
    end
    rdchk(OFS_COUNTER, 32'h00000064);
    $display("high limit test done");
  endtask
  task automatic t_low;
    bit hi, lo;
    wr(OFS_LOW_LIMIT, 32'hFFFFFFFD);
    wr(OFS_LOW_ACTION, 32'h00000035);
    wr(OFS_COUNTER, 32'hFFFFFFFD);
    step(1'b0, hi, lo);
    cmp("low fired", 32'h1, 32'(lo));
    cmp("low code", 32'h5, 32'(lc));
    cmp("low mask", 32'h4, 32'(lm));
    $display("low limit test done");
  endtask
  // Limits are now +3 and -3, so midway commands truncate
  task automatic t_scale;
    logic [31:0] cmd [3] = '{32'h000003E8, 32'hFFFFFC18, 32'h000001F4};
    logic [31:0] ex [3] = '{32'h00000003, 32'hFFFFFFFD, 32'h00000001};
    for (int i = 0; i < 3; i++) begin
      wr(OFS_REL_CMD, cmd[i]);
      rdchk(OFS_TARGET, ex[i]);
      cmp("target port", ex[i], tgt);
    end
    wr(OFS_TARGET, 32'h0, RESP_SLVERR);
    $display("scaling test done");
  endtask
  // Hall sensor keeps the search off while modes cycle
  task automatic t_mode;
    wr(OFS_EMF_COUPLING, 32'h0000AFC8);
    for (int m = 0; m < 4; m++) begin
      wr(OFS_MODE, 32'h100 | 32'(m));
      repeat (2) @(posedge clk);
      cmp("mode", 32'(m), 32'(mode));
      cmp("coupling", (m == 2) ? 32'h0000AFC8 : 32'h0, emf);
      cmp("search", 32'h0, 32'(sreq));
    end
    for (int s = 0; s < 6; s++) begin
      wr(OFS_MODE, 32'(s) << 8);
      repeat (2) @(posedge clk);
      cmp("sensor", 32'(s), 32'(sens));
    end
    wr(OFS_MODE, 32'h1);
    repeat (2) @(posedge clk);
    cmp("search", 32'h1, 32'(sreq));
    ref_search_done <= 1'b1;
    @(posedge clk);
    ref_search_done <= 1'b0;
    repeat (2) @(posedge clk);
    cmp("search", 32'h0, 32'(sreq));
    $display("mode test done");
  endtask
  task automatic t_home;
    bit hi, lo;
    wr(OFS_COUNTER, 32'h0);
    wr(OFS_CONTROL, 32'h1);
    rdchk(OFS_COUNTER, 32'h00000064);
    wr(OFS_COUNTER, 32'h0);
    home_switch <= 1'b1;
    repeat (8) @(posedge clk);
    home_switch <= 1'b0;
    rdchk(OFS_COUNTER, 32'h00000064);
    wr(OFS_POLE_PAIRS, 32'h000000FE);
    wr(OFS_COUNTER, 32'h0);
    step(1'b1, hi, lo);
    cmp("speed invert", 32'h1, 32'(inv));
    rdchk(OFS_COUNTER, 32'hFFFFFFFF);
    $display("home and pole test done");
  endtask
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_high();
    t_low();
    t_scale();
    t_mode();
    t_home();
    print_verdict();
  end
endmodule
`default_nettype wire

/* File: design/bclc_limit_watch.sv */
`timescale 1ns/10ps
`default_nettype none
module bclc_limit_watch #(
  parameter bit ABOVE = 1'b1 // 1 watches rising past limit, 0 falling below
) (
  input wire logic clk, // System clock
  input wire logic rst, // Synchronous reset
  input wire logic ce, // Clock enable
  input wire logic [31:0] count, // Signed position counter
  input wire logic [31:0] limit, // Signed limit
  input wire logic [7:0] action, // Action code and motor selection
  output logic stb, // One-cycle action pulse
  output logic [3:0] code, // Action code of the pulse
  output logic [2:0] motors // Motors the action applies to
);
  import bclc_pkg::*;

  typedef struct packed {
    logic prev; // Counter was beyond limit last cycle
    logic stb;
    logic [3:0] code;
    logic [2:0] motors;
  } bclc_lw_s;

  bclc_lw_s st_ff;
  bclc_lw_s nxt_st;
  logic hit;

  // Fire once per crossing so a parked counter does not retrigger
  always_comb begin
    nxt_st = st_ff;
    hit = ABOVE ? ($signed(count) > $signed(limit)) : ($signed(count) < $signed(limit));
    nxt_st.prev = hit;
    nxt_st.stb = hit && !st_ff.prev && (action[3:0] != ACT_NONE)
      && (action[3:0] <= ACT_HOME);
    if (nxt_st.stb) begin
      nxt_st.code = action[3:0];
      nxt_st.motors = motor_mask(action[7:4]);
    end
  end

  // State register
  always_ff @(posedge clk) begin
    if (rst) begin
      st_ff <= '0;
    end else if (ce) begin
      st_ff <= nxt_st;
    end
  end

  assign stb = st_ff.stb;
  assign code = st_ff.code;
  assign motors = st_ff.motors;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  property p_fire;
    ce && hit && !st_ff.prev && action[3:0] == 4'h4 |=> stb && code == 4'h4;
  endproperty
  a_fire: assert property (p_fire) else $error("limit crossing gave no action");
  property p_mask;
    stb && !$past(stb) |-> motors == motor_mask($past(action[7:4]));
  endproperty
  a_mask: assert property (p_mask) else $error("motor selection wrong");
  property p_none;
    ce && action[3:0] == ACT_NONE |=> !stb;
  endproperty
  a_none: assert property (p_none) else $error("code none fired");
  c_fire: cover property (stb);
endmodule
`default_nettype wire

/* File: design/bclc_pkg.sv */
package bclc_pkg;
  // Register byte offsets on the AXI4-Lite port
  localparam logic [7:0] OFS_MODE = 8'h00;
  localparam logic [7:0] OFS_HIGH_LIMIT = 8'h04;
  localparam logic [7:0] OFS_LOW_LIMIT = 8'h08;
  localparam logic [7:0] OFS_HIGH_ACTION = 8'h0C;
  localparam logic [7:0] OFS_LOW_ACTION = 8'h10;
  localparam logic [7:0] OFS_HOME_VALUE = 8'h14;
  localparam logic [7:0] OFS_EMF_COUPLING = 8'h18;
  localparam logic [7:0] OFS_POLE_PAIRS = 8'h1C;
  localparam logic [7:0] OFS_COUNTER = 8'h20;
  localparam logic [7:0] OFS_REL_CMD = 8'h24;
  localparam logic [7:0] OFS_TARGET = 8'h28;
  localparam logic [7:0] OFS_STATUS = 8'h2C;
  localparam logic [7:0] OFS_CONTROL = 8'h30;
  // Field positions
  localparam int MODE_LSB = 0;
  localparam int SENSOR_LSB = 8;
  localparam int ST_HIGH = 0;
  localparam int ST_LOW = 1;
  localparam int ST_SEARCH = 2;
  localparam int CTL_HOME = 0;
  // Reset values
  localparam logic [31:0] RST_HIGH_LIMIT = 32'h00004E20;
  localparam logic [31:0] RST_LOW_LIMIT = 32'hFFFFB1E0;
  localparam logic [31:0] RST_HOME_VALUE = 32'h00000000;
  localparam logic [31:0] RST_EMF_COUPLING = 32'h00000000;
  localparam logic [7:0] RST_ACTION = 8'h00;
  localparam logic [7:0] RST_POLE_PAIRS = 8'h02;
  // Relative command span: +span maps to high limit, -span to low limit
  localparam logic [31:0] REL_SPAN = 32'h000003E8;
  localparam logic [31:0] REL_MIN = 32'hFFFFFC18;
  // Commutation modes
  localparam logic [1:0] MODE_TRAP = 2'h0;
  localparam logic [1:0] MODE_SINE = 2'h1;
  localparam logic [1:0] MODE_SENSORLESS = 2'h2;
  localparam logic [1:0] MODE_ACIND = 2'h3;
  // Rotor sensors used in sinusoidal mode
  localparam logic [2:0] SNS_ENC = 3'h0;
  localparam logic [2:0] SNS_HALL_ENC = 3'h2;
  // Limit action codes
  localparam logic [3:0] ACT_NONE = 4'h0;
  localparam logic [3:0] ACT_HOME = 4'h8;
  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Upper nibble of an action byte: 1, 2 or 3 names motor one, two or three
  function automatic logic [2:0] motor_mask(input logic [3:0] sel);
    case (sel)
      4'h1: motor_mask = 3'h1;
      4'h2: motor_mask = 3'h2;
      4'h3: motor_mask = 3'h4;
      default: motor_mask = 3'h0;
    endcase
  endfunction
endpackage

/* File: design/bclc_pos_scaler.sv */
`timescale 1ns/10ps
`default_nettype none
module bclc_pos_scaler (
  input wire logic clk, // System clock
  input wire logic rst, // Synchronous reset
  input wire logic ce, // Clock enable
  input wire logic [31:0] cmd, // Signed relative command
  input wire logic [31:0] high, // Signed high limit
  input wire logic [31:0] low, // Signed low limit
  output logic [31:0] target // Signed position target
);
  import bclc_pkg::*;

  typedef struct packed {
    logic [31:0] target;
  } bclc_ps_s;

  localparam logic signed [44:0] DIV = 45'(2 * REL_SPAN);

  bclc_ps_s st_ff;
  bclc_ps_s nxt_st;
  logic signed [31:0] c;
  logic signed [11:0] off;
  logic signed [32:0] span;
  logic signed [44:0] prod;
  logic signed [44:0] q;

  // Clamp the command, then interpolate across the travel range
  always_comb begin
    nxt_st = st_ff;
    if ($signed(cmd) > $signed(REL_SPAN)) begin
      c = $signed(REL_SPAN);
    end else if ($signed(cmd) < $signed(REL_MIN)) begin
      c = $signed(REL_MIN);
    end else begin
      c = $signed(cmd);
    end
    off = $signed(12'(c + $signed(REL_SPAN)));
    span = $signed({high[31], high}) - $signed({low[31], low});
    prod = span * off;
    // Division by a constant keeps this one cycle at the cost of area
    q = prod / DIV;
    nxt_st.target = low + q[31:0];
  end

  // State register
  always_ff @(posedge clk) begin
    if (rst) begin
      st_ff <= '0;
    end else if (ce) begin
      st_ff <= nxt_st;
    end
  end

  assign target = st_ff.target;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  property p_top;
    ce && cmd == REL_SPAN |=> target == $past(high);
  endproperty
  a_top: assert property (p_top) else $error("full command missed high");
  property p_bot;
    ce && cmd == REL_MIN |=> target == $past(low);
  endproperty
  a_bot: assert property (p_bot) else $error("negative command missed low");
  c_top: cover property (ce && cmd == REL_SPAN);
endmodule
`default_nettype wire

/* File: design/bclc_top.sv */
// Our own choices: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/10ps
`default_nettype none
module bclc_top (
  input wire logic clk, // System clock, 250 MHz
  input wire logic rst, // Synchronous reset, active high
  input wire logic ce, // Clock enable, freezes all state when low
  input wire logic [7:0] s_axi_awaddr, // Write address
  input wire logic s_axi_awvalid, // Write address valid
  output logic s_axi_awready, // Write address ready
  input wire logic [31:0] s_axi_wdata, // Write data
  input wire logic [3:0] s_axi_wstrb, // Write byte strobes
  input wire logic s_axi_wvalid, // Write data valid
  output logic s_axi_wready, // Write data ready
  output logic [1:0] s_axi_bresp, // Write response
  output logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  input wire logic [7:0] s_axi_araddr, // Read address
  input wire logic s_axi_arvalid, // Read address valid
  output logic s_axi_arready, // Read address ready
  output logic [31:0] s_axi_rdata, // Read data
  output logic [1:0] s_axi_rresp, // Read response
  output logic s_axi_rvalid, // Read data valid
  input wire logic s_axi_rready, // Read data ready
  input wire logic hall_step, // One hall transition, same clock
  input wire logic hall_dir, // Transition direction, 1 forward
  input wire logic home_switch, // Home switch pin, asynchronous
  input wire logic ref_search_done, // Reference search finished
  output logic high_act_stb, // High limit action pulse
  output logic [3:0] high_act_code, // High limit action code
  output logic [2:0] high_act_motors, // High limit motor mask
  output logic low_act_stb, // Low limit action pulse
  output logic [3:0] low_act_code, // Low limit action code
  output logic [2:0] low_act_motors, // Low limit motor mask
  output logic [1:0] commutation_mode, // Selected commutation mode
  output logic [2:0] rotor_sensor_select, // Selected rotor sensor
  output logic [31:0] emf_coupling_constant, // Applied coupling, 0 unless sensorless
  output logic speed_invert, // Measured speed polarity inverted
  output logic ref_search_req, // Rotor reference search requested
  output logic [31:0] position_target // Scaled position target
);
  import bclc_pkg::*;

  typedef enum logic [1:0] {
    SRCH_IDLE = 2'b01,
    SRCH_BUSY = 2'b10
  } bclc_srch_e;

  typedef struct packed {
    logic aw_rdy; // Write address slot free
    logic aw_got; // Write address held
    logic [7:0] aw_addr;
    logic w_rdy; // Write data slot free
    logic w_got; // Write data held
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic ar_rdy;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [1:0] mode;
    logic [2:0] sensor;
    logic [31:0] hi;
    logic [31:0] lo;
    logic [31:0] home;
    logic [31:0] emf;
    logic [31:0] cnt;
    logic [31:0] rel;
    logic [7:0] hact;
    logic [7:0] lact;
    logic [7:0] poles;
    logic [1:0] sticky; // Limit actions fired, write one to clear
    bclc_srch_e srch;
    logic [31:0] emf_out;
    logic spd_inv;
    logic home_cmd; // Software home request, one cycle
    logic [2:0] sync; // Home switch synchroniser
    logic home_filt; // Settled home switch level
  } bclc_top_s;

  localparam bclc_top_s ST_RST = '{
    aw_rdy: 1'b1, w_rdy: 1'b1, ar_rdy: 1'b1,
    hi: RST_HIGH_LIMIT, lo: RST_LOW_LIMIT,
    home: RST_HOME_VALUE, emf: RST_EMF_COUPLING,
    hact: RST_ACTION, lact: RST_ACTION, poles: RST_POLE_PAIRS,
    mode: MODE_TRAP, sensor: SNS_ENC, srch: SRCH_IDLE,
    default: '0
  };

  bclc_top_s st_ff;
  bclc_top_s nxt_st;
  logic hi_stb;
  logic [3:0] hi_code;
  logic lo_stb;
  logic [3:0] lo_code;
  logic wr;
  logic [31:0] wv;
  logic cnt_wr;
  logic home_evt;
  logic srch_start;

  // Byte-lane merge of a write into the old register value
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                        input logic [3:0] s);
    for (int i = 0; i < 4; i++) begin
      merge[i*8 +: 8] = s[i] ? d[i*8 +: 8] : old[i*8 +: 8];
    end
  endfunction

  // High limit watcher
  bclc_limit_watch #(
    .ABOVE(1'b1)
  ) u_high (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .count(st_ff.cnt),
    .limit(st_ff.hi),
    .action(st_ff.hact),
    .stb(hi_stb),
    .code(hi_code),
    .motors(high_act_motors)
  );

  // Low limit watcher, same action encoding
  bclc_limit_watch #(
    .ABOVE(1'b0)
  ) u_low (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .count(st_ff.cnt),
    .limit(st_ff.lo),
    .action(st_ff.lact),
    .stb(lo_stb),
    .code(lo_code),
    .motors(low_act_motors)
  );

  // Relative command onto the travel range
  bclc_pos_scaler u_scale (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .cmd(st_ff.rel),
    .high(st_ff.hi),
    .low(st_ff.lo),
    .target(position_target)
  );

  // Bus slave, register file and counter
  always_comb begin
    nxt_st = st_ff;
    cnt_wr = 1'b0;
    srch_start = 1'b0;
    home_evt = 1'b0;
    // Address and data are taken independently, in either order
    if (s_axi_awvalid && st_ff.aw_rdy) begin
      nxt_st.aw_got = 1'b1;
      nxt_st.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && st_ff.w_rdy) begin
      nxt_st.w_got = 1'b1;
      nxt_st.wdata = s_axi_wdata;
      nxt_st.wstrb = s_axi_wstrb;
    end
    if (st_ff.bvalid && s_axi_bready) begin
      nxt_st.bvalid = 1'b0;
    end
    nxt_st.home_cmd = 1'b0;
    wr = st_ff.aw_got && st_ff.w_got && !st_ff.bvalid;
    wv = '0;
    if (wr) begin
      nxt_st.aw_got = 1'b0;
      nxt_st.w_got = 1'b0;
      nxt_st.bvalid = 1'b1;
      nxt_st.bresp = RESP_OKAY;
      case (st_ff.aw_addr)
        OFS_MODE: begin
          wv = merge({21'h0, st_ff.sensor, 6'h0, st_ff.mode}, st_ff.wdata, st_ff.wstrb);
          nxt_st.mode = wv[MODE_LSB +: 2];
          nxt_st.sensor = wv[SENSOR_LSB +: 3];
          // Entering sine mode on an encoder needs the rotor angle first
          srch_start = (nxt_st.mode == MODE_SINE) && (st_ff.mode != MODE_SINE)
            && (nxt_st.sensor == SNS_ENC || nxt_st.sensor == SNS_HALL_ENC);
        end
        OFS_HIGH_LIMIT: nxt_st.hi = merge(st_ff.hi, st_ff.wdata, st_ff.wstrb);
        OFS_LOW_LIMIT: nxt_st.lo = merge(st_ff.lo, st_ff.wdata, st_ff.wstrb);
        OFS_HIGH_ACTION: begin
          if (st_ff.wstrb[0]) begin
            nxt_st.hact = st_ff.wdata[7:0];
          end
        end
        OFS_LOW_ACTION: begin
          if (st_ff.wstrb[0]) begin
            nxt_st.lact = st_ff.wdata[7:0];
          end
        end
        OFS_HOME_VALUE: nxt_st.home = merge(st_ff.home, st_ff.wdata, st_ff.wstrb);
        OFS_EMF_COUPLING: nxt_st.emf = merge(st_ff.emf, st_ff.wdata, st_ff.wstrb);
        OFS_POLE_PAIRS: begin
          if (st_ff.wstrb[0]) begin
            nxt_st.poles = st_ff.wdata[7:0];
          end
        end
        OFS_COUNTER: begin
          // Safe only in open loop; the host keeps to that
          nxt_st.cnt = merge(st_ff.cnt, st_ff.wdata, st_ff.wstrb);
          cnt_wr = 1'b1;
        end
        OFS_REL_CMD: nxt_st.rel = merge(st_ff.rel, st_ff.wdata, st_ff.wstrb);
        OFS_STATUS: begin
          if (st_ff.wstrb[0]) begin
            nxt_st.sticky = st_ff.sticky & ~st_ff.wdata[1:0];
          end
        end
        OFS_CONTROL: nxt_st.home_cmd = st_ff.wstrb[0] && st_ff.wdata[CTL_HOME];
        OFS_TARGET: nxt_st.bresp = RESP_SLVERR;
        default: nxt_st.bresp = RESP_SLVERR;
      endcase
    end
    // Read channel, data registered one cycle after the address
    if (st_ff.rvalid && s_axi_rready) begin
      nxt_st.rvalid = 1'b0;
    end
    if (s_axi_arvalid && st_ff.ar_rdy) begin
      nxt_st.rvalid = 1'b1;
      nxt_st.rresp = RESP_OKAY;
      case (s_axi_araddr)
        OFS_MODE: nxt_st.rdata = {21'h0, st_ff.sensor, 6'h0, st_ff.mode};
        OFS_HIGH_LIMIT: nxt_st.rdata = st_ff.hi;
        OFS_LOW_LIMIT: nxt_st.rdata = st_ff.lo;
        OFS_HIGH_ACTION: nxt_st.rdata = {24'h0, st_ff.hact};
        OFS_LOW_ACTION: nxt_st.rdata = {24'h0, st_ff.lact};
        OFS_HOME_VALUE: nxt_st.rdata = st_ff.home;
        OFS_EMF_COUPLING: nxt_st.rdata = st_ff.emf;
        OFS_POLE_PAIRS: nxt_st.rdata = {24'h0, st_ff.poles};
        OFS_COUNTER: nxt_st.rdata = st_ff.cnt;
        OFS_REL_CMD: nxt_st.rdata = st_ff.rel;
        OFS_TARGET: nxt_st.rdata = position_target;
        OFS_STATUS: nxt_st.rdata = {29'h0, st_ff.srch == SRCH_BUSY, st_ff.sticky};
        OFS_CONTROL: nxt_st.rdata = '0;
        default: begin
          nxt_st.rdata = '0;
          nxt_st.rresp = RESP_SLVERR;
        end
      endcase
    end
    // Home switch: first stage feeds only the second
    nxt_st.sync = {st_ff.sync[1:0], home_switch};
    if (st_ff.sync[1] == st_ff.sync[2]) begin
      nxt_st.home_filt = st_ff.sync[2];
    end
    // Switch edge, software command, or a limit action asking for home
    home_evt = (nxt_st.home_filt && !st_ff.home_filt) || st_ff.home_cmd
      || (hi_stb && hi_code == ACT_HOME) || (lo_stb && lo_code == ACT_HOME);
    // Home load beats a software write, which beats a hall step
    if (home_evt) begin
      nxt_st.cnt = st_ff.home;
    end else if (!cnt_wr && hall_step) begin
      if (hall_dir ^ st_ff.poles[7]) begin
        nxt_st.cnt = st_ff.cnt + 32'h00000001;
      end else begin
        nxt_st.cnt = st_ff.cnt - 32'h00000001;
      end
    end
    // Hardware set wins over a same-cycle clear
    if (hi_stb) begin
      nxt_st.sticky[ST_HIGH] = 1'b1;
    end
    if (lo_stb) begin
      nxt_st.sticky[ST_LOW] = 1'b1;
    end
    // Reference search runs until commutation reports done
    case (st_ff.srch)
      SRCH_IDLE: begin
        if (srch_start) begin
          nxt_st.srch = SRCH_BUSY;
        end
      end
      SRCH_BUSY: begin
        if (ref_search_done) begin
          nxt_st.srch = SRCH_IDLE;
        end
      end
      default: nxt_st.srch = SRCH_IDLE;
    endcase
    nxt_st.emf_out = (nxt_st.mode == MODE_SENSORLESS) ? nxt_st.emf : '0;
    nxt_st.spd_inv = nxt_st.poles[7];
    // Ready flags: one outstanding write and one read at a time
    nxt_st.aw_rdy = !nxt_st.aw_got && !nxt_st.bvalid;
    nxt_st.w_rdy = !nxt_st.w_got && !nxt_st.bvalid;
    nxt_st.ar_rdy = !nxt_st.rvalid;
  end

  // State register; reset acts even with the clock enable low
  always_ff @(posedge clk) begin
    if (rst) begin
      st_ff <= ST_RST;
    end else if (ce) begin
      st_ff <= nxt_st;
    end
  end

  assign s_axi_awready = st_ff.aw_rdy;
  assign s_axi_wready = st_ff.w_rdy;
  assign s_axi_bvalid = st_ff.bvalid;
  assign s_axi_bresp = st_ff.bresp;
  assign s_axi_arready = st_ff.ar_rdy;
  assign s_axi_rvalid = st_ff.rvalid;
  assign s_axi_rdata = st_ff.rdata;
  assign s_axi_rresp = st_ff.rresp;
  assign high_act_stb = hi_stb;
  assign high_act_code = hi_code;
  assign low_act_stb = lo_stb;
  assign low_act_code = lo_code;
  assign commutation_mode = st_ff.mode;
  assign rotor_sensor_select = st_ff.sensor;
  assign emf_coupling_constant = st_ff.emf_out;
  assign speed_invert = st_ff.spd_inv;
  assign ref_search_req = st_ff.srch[1];

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  property p_hi_rst;
    $fell(rst) |-> st_ff.hi == RST_HIGH_LIMIT && !high_act_stb;
  endproperty
  a_hi_rst: assert property (p_hi_rst) else $error("high limit reset wrong");
  property p_lo_rst;
    $fell(rst) |-> st_ff.lo == RST_LOW_LIMIT && st_ff.lact == RST_ACTION;
  endproperty
  a_lo_rst: assert property (p_lo_rst) else $error("low limit reset wrong");
  property p_mode_rst;
    $fell(rst) |-> commutation_mode == MODE_TRAP && st_ff.hact == RST_ACTION;
  endproperty
  a_mode_rst: assert property (p_mode_rst) else $error("mode reset wrong");
  property p_sns_rst;
    $fell(rst) |-> rotor_sensor_select == SNS_ENC;
  endproperty
  a_sns_rst: assert property (p_sns_rst) else $error("sensor reset wrong");
  property p_home;
    ce && home_evt |=> st_ff.cnt == $past(st_ff.home);
  endproperty
  a_home: assert property (p_home) else $error("home value not loaded");
  property p_search;
    ce && srch_start |=> ref_search_req ##1 (ref_search_req || $past(ref_search_done));
  endproperty
  a_search: assert property (p_search) else $error("search not started");
  property p_emf;
    commutation_mode != MODE_SENSORLESS |-> emf_coupling_constant == '0;
  endproperty
  a_emf: assert property (p_emf) else $error("coupling used outside sensorless");
  property p_pole;
    ce && hall_step && hall_dir && st_ff.poles[7] && !home_evt && !cnt_wr
      |=> st_ff.cnt == $past(st_ff.cnt) - 32'h00000001 && speed_invert;
  endproperty
  a_pole: assert property (p_pole) else $error("negative poles not inverted");
  c_home: cover property (ce && home_evt);
  c_search: cover property (ref_search_req ##1 !ref_search_req);
endmodule
`default_nettype wire
